// File: adc_ctrl_pkg.sv
// Purpose: shared constants and types of the converter control block
// Assumes: one 125 MHz clock, registers reach the block as plain ports
// Notes:   pump start-up time is a plain default, not a device figure
package adc_ctrl_pkg;
   localparam int RES_W = 12;
   localparam int ACC_W = 19;
   localparam int SUM_W = 21;
   localparam int CNT_W = 8;
   localparam int FLT_W = 16;
   localparam int SRC_N = 32;
   localparam int SEL_W = 5;
   localparam int ACQ_W = 8;
   localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
   localparam logic [ACC_W-1:0] ACC_RST = 19'h0_0000;
   localparam logic [SUM_W-1:0] ACC_LIM = 21'h03_FFFF;
   localparam int CLK_NS        = 8;
   localparam int PUMP_START_NS = 2000;
   localparam int PUMP_CYC_I    = (PUMP_START_NS + CLK_NS - 1) / CLK_NS;
   localparam int PUMP_W        = 9;
   localparam logic [PUMP_W-1:0] PUMP_CYC = PUMP_CYC_I[PUMP_W-1:0];
   typedef enum logic [2:0] {
      MD_BASIC = 3'h0,
      MD_ACCUM = 3'h1,
      MD_AVG   = 3'h2,
      MD_BURST = 3'h3,
      MD_LPF   = 3'h4
   } mode_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ACQ  = 2'b01,
      ST_CONV = 2'b10,
      ST_POST = 2'b11
   } state_t;
   typedef struct packed {
      mode_t            mode;
      logic [2:0]       shift_amount;
      logic [CNT_W-1:0] rpt;
      logic             double_sample_enable;
      logic             continuous_enable;
   } cfg_t;
endpackage

// File: trig_edge_sync.sv
// Purpose: synchronise trigger pins and flag a rising edge of the chosen one
// Assumes: sources are asynchronous to clk
// Notes:   a change of select may itself look like one edge
`timescale 1ns/100ps
`default_nettype none
module trig_edge_sync
(
   input  wire logic                                clk,
   input  wire logic                                sys_rst,
   input  wire logic                                ce,
   input  wire logic [adc_ctrl_pkg::SRC_N-1:0]      src,
   input  wire logic [adc_ctrl_pkg::SEL_W-1:0]      sel,
   output logic                                     rise_r
);
   logic [adc_ctrl_pkg::SRC_N-1:0] s1_r;
   logic [adc_ctrl_pkg::SRC_N-1:0] s2_r;
   logic                           lvl_r;

   genvar i;
   generate
      for (i = 0; i < adc_ctrl_pkg::SRC_N; i++)
      begin : g_sync
         always_ff @(posedge clk or posedge sys_rst)
         begin
            if (sys_rst)
            begin
               s1_r[i] <= 1'b0;
               s2_r[i] <= 1'b0;
            end
            else if (ce)
            begin
               s1_r[i] <= src[i];
               s2_r[i] <= s1_r[i];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         lvl_r  <= 1'b0;
         rise_r <= 1'b0;
      end
      else if (ce)
      begin
         lvl_r  <= s2_r[sel];
         rise_r <= s2_r[sel] & ~lvl_r;
      end
   end
endmodule
`default_nettype wire

// File: adc_trigger_and_computation.sv
// Purpose: trigger, acquisition, pump and computation control of a 12-bit converter
// Assumes: analog core shares clk; conv_done is a one-cycle pulse with its data
// Notes:   threshold comparator sits outside and answers on thresh_met
`timescale 1ns/100ps
`default_nettype none
module adc_trigger_and_computation
(
   input  wire logic                                clk,
   input  wire logic                                sys_rst,
   input  wire logic                                ce,
   input  wire logic                                adc_on,
   input  wire adc_ctrl_pkg::cfg_t                  compute_control_reg,
   input  wire logic [adc_ctrl_pkg::SEL_W-1:0]      auto_trigger_select,
   input  wire logic [adc_ctrl_pkg::SRC_N-1:0]      trig_src,
   input  wire logic                                sleep_mode,
   input  wire logic                                dedicated_rc_clock,
   input  wire logic [adc_ctrl_pkg::ACQ_W-1:0]      acquisition_count,
   input  wire logic                                go_set,
   input  wire logic                                accum_clear_set,
   input  wire logic                                done_clr,
   input  wire logic                                thr_clr,
   input  wire logic                                pump_enable,
   input  wire logic                                conv_done,
   input  wire logic [adc_ctrl_pkg::RES_W-1:0]      conv_data,
   input  wire logic                                thresh_met,
   output logic                                     conv_start,
   output logic                                     thresh_test,
   output logic                                     go_r,
   output logic                                     conv_done_flag,
   output logic                                     threshold_flag,
   output logic                                     overflow_flag,
   output logic                                     accum_clear_cmd,
   output logic                                     pump_ready_flag,
   output logic [adc_ctrl_pkg::ACC_W-1:0]           accumulator_value,
   output logic [adc_ctrl_pkg::CNT_W-1:0]           sample_counter,
   output logic [adc_ctrl_pkg::FLT_W-1:0]           filter_output,
   output logic [adc_ctrl_pkg::RES_W-1:0]           conversion_result,
   output logic [adc_ctrl_pkg::RES_W-1:0]           prev_result
);
   adc_ctrl_pkg::state_t              st_r;
   adc_ctrl_pkg::mode_t               md;
   logic [adc_ctrl_pkg::ACQ_W-1:0]    acq_r;
   logic [adc_ctrl_pkg::PUMP_W-1:0]   pump_r;
   logic                              phase_r;
   logic                              pend_r;
   logic                              burst_r;
   logic                              trig_rise;
   logic                              hold_sleep;
   logic                              start;
   logic                              start_clr;
   logic                              last_conv;
   logic                              accum_on;
   logic                              at_rpt;
   logic                              test_cond;
   logic                              more_burst;
   logic                              ovf_hit;
   logic signed [adc_ctrl_pkg::SUM_W-1:0] acc_s;
   logic signed [adc_ctrl_pkg::SUM_W-1:0] d_s;
   logic signed [adc_ctrl_pkg::SUM_W-1:0] sum_nxt;

   assign md = compute_control_reg.mode;

   trig_edge_sync u_trig
   (
      .clk    (clk),
      .sys_rst(sys_rst),
      .ce     (ce),
      .src    (trig_src),
      .sel    (auto_trigger_select),
      .rise_r (trig_rise)
   );

   // only the rc clock keeps running in sleep
   assign hold_sleep = sleep_mode & ~dedicated_rc_clock;
   assign start      = (st_r == adc_ctrl_pkg::ST_IDLE) & go_r & adc_on & ~hold_sleep;
   assign at_rpt     = sample_counter >= compute_control_reg.rpt;
   assign start_clr  = start & (((md == adc_ctrl_pkg::MD_AVG) & at_rpt)
                      | ((md == adc_ctrl_pkg::MD_BURST) & ~burst_r));
   assign last_conv  = conv_done & (st_r == adc_ctrl_pkg::ST_CONV)
                      & (~compute_control_reg.double_sample_enable | phase_r);
   assign accum_on   = md != adc_ctrl_pkg::MD_BASIC;
   assign conv_start = (st_r == adc_ctrl_pkg::ST_ACQ) & (acq_r == '0);
   assign test_cond  = (md == adc_ctrl_pkg::MD_BASIC) | (md == adc_ctrl_pkg::MD_ACCUM)
                      | at_rpt;
   assign thresh_test = (st_r == adc_ctrl_pkg::ST_POST) & test_cond;
   assign more_burst = (md == adc_ctrl_pkg::MD_BURST) & ~at_rpt;

   // accumulation arithmetic, widened so the overflow is visible
   always_comb
   begin
      acc_s = {{(adc_ctrl_pkg::SUM_W-adc_ctrl_pkg::ACC_W){accumulator_value[adc_ctrl_pkg::ACC_W-1]}},
               accumulator_value};
      if (compute_control_reg.double_sample_enable)
         d_s = $signed({{(adc_ctrl_pkg::SUM_W-adc_ctrl_pkg::RES_W){1'b0}}, conv_data})
             - $signed({{(adc_ctrl_pkg::SUM_W-adc_ctrl_pkg::RES_W){1'b0}}, conversion_result});
      else
         d_s = $signed({{(adc_ctrl_pkg::SUM_W-adc_ctrl_pkg::RES_W){1'b0}}, conv_data});
      if (md == adc_ctrl_pkg::MD_LPF)
         sum_nxt = acc_s + d_s - (acc_s >>> compute_control_reg.shift_amount);
      else
         sum_nxt = acc_s + d_s;
      ovf_hit = accum_on & last_conv & (sum_nxt > $signed(adc_ctrl_pkg::ACC_LIM));
   end

   // conversion sequencer
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_r    <= adc_ctrl_pkg::ST_IDLE;
         acq_r   <= '0;
         phase_r <= 1'b0;
      end
      else if (ce)
      begin
         case (st_r)
            adc_ctrl_pkg::ST_IDLE:
            begin
               phase_r <= 1'b0;
               if (start)
               begin
                  acq_r <= acquisition_count;
                  st_r  <= adc_ctrl_pkg::ST_ACQ;
               end
            end
            adc_ctrl_pkg::ST_ACQ:
            begin
               if (acq_r != '0)
                  acq_r <= acq_r - 1'b1;
               else
                  st_r <= adc_ctrl_pkg::ST_CONV;
            end
            adc_ctrl_pkg::ST_CONV:
            begin
               if (last_conv)
                  st_r <= adc_ctrl_pkg::ST_POST;
               else if (conv_done)
               begin
                  phase_r <= 1'b1;
                  acq_r   <= acquisition_count;
                  st_r    <= adc_ctrl_pkg::ST_ACQ;
               end
            end
            adc_ctrl_pkg::ST_POST:
               st_r <= adc_ctrl_pkg::ST_IDLE;
            default:
               st_r <= adc_ctrl_pkg::ST_IDLE;
         endcase
      end
   end

   // start bit, deferred sleep trigger and burst run
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         go_r    <= 1'b0;
         pend_r  <= 1'b0;
         burst_r <= 1'b0;
      end
      else if (ce)
      begin
         if (trig_rise & hold_sleep)
            pend_r <= 1'b1;
         else if (~hold_sleep)
            pend_r <= 1'b0;
         if (go_set | (trig_rise & ~hold_sleep) | (pend_r & ~hold_sleep))
            go_r <= 1'b1;
         else if ((st_r == adc_ctrl_pkg::ST_POST) & ~compute_control_reg.continuous_enable
                  & ~more_burst)
            go_r <= 1'b0;
         if (st_r == adc_ctrl_pkg::ST_POST)
            burst_r <= more_burst;
         else if (start & (md == adc_ctrl_pkg::MD_BURST))
            burst_r <= 1'b1;
      end
   end

   // results, accumulator and counter
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         conversion_result <= '0;
         prev_result       <= '0;
         accumulator_value <= adc_ctrl_pkg::ACC_RST;
         sample_counter    <= '0;
         filter_output     <= '0;
      end
      else if (ce)
      begin
         if (conv_done & (st_r == adc_ctrl_pkg::ST_CONV))
         begin
            conversion_result <= conv_data;
            prev_result       <= conversion_result;
         end
         if (accum_clear_cmd | start_clr)
         begin
            accumulator_value <= adc_ctrl_pkg::ACC_RST;
            sample_counter    <= '0;
         end
         else if (accum_on & last_conv)
         begin
            accumulator_value <= sum_nxt[adc_ctrl_pkg::ACC_W-1:0];
            filter_output     <= 16'(sum_nxt >>> compute_control_reg.shift_amount);
            if (sample_counter != adc_ctrl_pkg::CNT_MAX)
               sample_counter <= sample_counter + adc_ctrl_pkg::CNT_ONE;
         end
      end
   end

   // status flags: a hardware set wins over a software clear
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         conv_done_flag  <= 1'b0;
         threshold_flag  <= 1'b0;
         overflow_flag   <= 1'b0;
         accum_clear_cmd <= 1'b0;
      end
      else if (ce)
      begin
         // basic mode waits for the pair; other modes flag each sample
         if ((st_r == adc_ctrl_pkg::ST_POST)
             | (accum_on & conv_done & (st_r == adc_ctrl_pkg::ST_CONV)))
            conv_done_flag <= 1'b1;
         else if (done_clr)
            conv_done_flag <= 1'b0;
         if (thresh_test & (thresh_met | overflow_flag))
            threshold_flag <= 1'b1;
         else if (thr_clr)
            threshold_flag <= 1'b0;
         if (ovf_hit)
            overflow_flag <= 1'b1;
         else if (accum_clear_cmd)
            overflow_flag <= 1'b0;
         // clearing takes the one cycle in which the command stands
         accum_clear_cmd <= accum_clear_set;
      end
   end

   // pump start-up timer
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pump_r          <= '0;
         pump_ready_flag <= 1'b0;
      end
      else if (ce)
      begin
         if (~pump_enable)
         begin
            pump_r          <= '0;
            pump_ready_flag <= 1'b0;
         end
         else if (pump_r != adc_ctrl_pkg::PUMP_CYC)
            pump_r <= pump_r + 1'b1;
         else
            pump_ready_flag <= 1'b1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst || !ce);

   sequence s_final;
      last_conv ##1 (st_r == adc_ctrl_pkg::ST_POST);
   endsequence
   sequence s_start_acq;
      start ##1 (st_r == adc_ctrl_pkg::ST_ACQ);
   endsequence

   a_done_after_final: assert property (s_final |=> conv_done_flag)
      else $error("done flag missing after final conversion");
   a_go_clears: assert property (s_final ##0 (!compute_control_reg.continuous_enable && !more_burst
                && !go_set && !trig_rise && !pend_r) |=> !go_r)
      else $error("start bit not cleared at completion");
   a_auto_go: assert property (trig_rise && !hold_sleep |=> go_r)
      else $error("auto trigger did not set start bit");
   a_sleep_defer: assert property (hold_sleep && st_r == adc_ctrl_pkg::ST_IDLE
                  |=> st_r == adc_ctrl_pkg::ST_IDLE)
      else $error("conversion began in sleep without rc clock");
   a_acq_wait: assert property (s_start_acq ##0 (acq_r != '0) |-> !conv_start)
      else $error("conversion started before acquisition");
   a_cnt_sat: assert property (sample_counter == adc_ctrl_pkg::CNT_MAX && !accum_clear_cmd
              && !start_clr |=> sample_counter == adc_ctrl_pkg::CNT_MAX)
      else $error("sample counter wrapped");
   a_accum_clear_cmd_clears: assert property (accum_clear_cmd && !accum_clear_set |=> accumulator_value == adc_ctrl_pkg::ACC_RST
                  && sample_counter == '0 && !accum_clear_cmd)
      else $error("clear command did not clear");
   a_pump_wait: assert property ($rose(pump_enable) |=> !pump_ready_flag[*8])
      else $error("pump ready too early");
   a_basic_hold: assert property (md == adc_ctrl_pkg::MD_BASIC && !accum_clear_cmd
                 |=> $stable(accumulator_value))
      else $error("basic mode changed the accumulator");
   a_thr_flag: assert property (thresh_test && thresh_met |=> threshold_flag)
      else $error("threshold flag not set");
   a_ovf_flag: assert property (ovf_hit |=> overflow_flag)
      else $error("overflow flag not set");
endmodule
`default_nettype wire

// File: analog_core_model.sv
// Purpose: analog core stand-in answering conversion requests
// Assumes: one request at a time, answer after dly plus one cycles
// Notes:   data shows the inverse of its last value outside a done pulse
`timescale 1ns/100ps
`default_nettype none
module analog_core_model
(
   input  wire logic                           clk,
   input  wire logic                           sys_rst,
   input  wire logic                           conv_start,
   input  wire logic [7:0]                     dly,
   input  wire logic [adc_ctrl_pkg::RES_W-1:0] data_in,
   output logic                                conv_done,
   output logic [adc_ctrl_pkg::RES_W-1:0]      conv_data
);
   logic [7:0] wait_r;
   logic       busy_r;
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         busy_r <= 1'b0;
         wait_r <= 8'h00;
         conv_done <= 1'b0;
         conv_data <= 12'h000;
      end
      else
      begin
         conv_done <= 1'b0;
         conv_data <= ~conv_data;
         if (conv_start)
         begin
            busy_r <= 1'b1;
            wait_r <= dly;
         end
         else if (busy_r && wait_r == 8'h00)
         begin
            busy_r <= 1'b0;
            conv_done <= 1'b1;
            conv_data <= data_in;
         end
         else if (busy_r)
            wait_r <= wait_r - 8'h01;
      end
   end
endmodule
`default_nettype wire

// File: testbench.sv
// Purpose: self-checking bench of the converter control block
// Assumes: ce tied high; analog core modelled behaviourally
// Notes:   data kept small in the long accumulate run so the accumulator never overflows
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic adc_on, sleep_mode, rc, go_set, clr_set, done_clr, thr_clr, pump_en, thr_in;
   adc_ctrl_pkg::cfg_t cfg;
   logic [4:0] sel;
   logic [31:0] src, seed;
   logic [7:0] acq, dly, cnt_v;
   logic [11:0] data_in, mask, conv_data, res_v, last_raw, prev_v, prev_raw;
   logic conv_start, thresh_test, go_r, done_f, thr_f, ovf_f, clr_cmd, rdy, conv_done;
   logic [18:0] acc_v;
   logic [15:0] flt_v;
   int err_count, compares, cyc, tests, exp_tests, acc, cnt, n;
   int samples[$];
   adc_trigger_and_computation u_dut (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .adc_on(adc_on),
      .compute_control_reg(cfg), .auto_trigger_select(sel), .trig_src(src), .sleep_mode(sleep_mode),
      .dedicated_rc_clock(rc), .acquisition_count(acq), .go_set(go_set), .accum_clear_set(clr_set),
      .done_clr(done_clr), .thr_clr(thr_clr), .pump_enable(pump_en), .conv_done(conv_done),
      .conv_data(conv_data), .thresh_met(thr_in), .conv_start(conv_start), .thresh_test(thresh_test),
      .go_r(go_r), .conv_done_flag(done_f), .threshold_flag(thr_f), .overflow_flag(ovf_f),
      .accum_clear_cmd(clr_cmd), .pump_ready_flag(rdy), .accumulator_value(acc_v), .sample_counter(cnt_v),
      .filter_output(flt_v), .conversion_result(res_v), .prev_result(prev_v));
   analog_core_model u_core (.clk(clk), .sys_rst(sys_rst), .conv_start(conv_start), .dly(dly),
      .data_in(data_in), .conv_done(conv_done), .conv_data(conv_data));
   always #4 clk = ~clk;
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   always @(negedge clk)
   begin
      seed <= xs(seed);
      data_in <= seed[11:0] & mask;
      dly <= {5'h00, seed[14:12]};
   end
   always @(posedge clk)
   begin
      if (conv_done === 1'b1)
      begin
         samples.push_back(int'(conv_data));
         last_raw <= conv_data;
         prev_raw <= last_raw;
      end
      if (thresh_test === 1'b1)
         tests++;
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, msg, got, exp);
      end
   endtask
   task automatic pre_clear();
      if ((cfg.mode == adc_ctrl_pkg::MD_AVG && cnt >= cfg.rpt) || cfg.mode == adc_ctrl_pkg::MD_BURST)
      begin
         acc = 0;
         cnt = 0;
      end
   endtask
   task automatic wait_idle();
      int s;
      n = 0;
      while (go_r !== 1'b0 && n < 3000)
      begin
         @(negedge clk);
         n++;
      end
      repeat (2) @(negedge clk);
      check({31'h0, done_f}, 1, "done flag");
      check({20'h0, res_v}, {20'h0, last_raw}, "result");
      check({20'h0, prev_v}, {20'h0, prev_raw}, "previous result");
      while (samples.size() > 0)
      begin
         s = samples.pop_front();
         if (cfg.double_sample_enable && samples.size() > 0)
            s = samples.pop_front() - s;
         if (cfg.mode != adc_ctrl_pkg::MD_BASIC)
         begin
            if (cfg.mode == adc_ctrl_pkg::MD_LPF)
               acc = s + acc - (acc >>> cfg.shift_amount);
            else
               acc = acc + s;
            if (cnt < 255)
               cnt++;
         end
         if (cfg.mode <= adc_ctrl_pkg::MD_ACCUM || cnt >= cfg.rpt)
            exp_tests++;
      end
      check(32'($signed(acc_v)), acc, "accumulator");
      check({24'h0, cnt_v}, cnt, "counter");
      check({16'h0, flt_v}, (acc >>> cfg.shift_amount) & 32'h0000_FFFF, "filter");
      check(tests, exp_tests, "test count");
      done_clr = 1'b1;
      @(negedge clk);
      done_clr = 1'b0;
   endtask
   task automatic run_go();
      pre_clear();
      @(negedge clk);
      go_set = 1'b1;
      @(negedge clk);
      go_set = 1'b0;
      wait_idle();
   endtask
   task automatic edge_on(input int b);
      src = 32'h0000_0000;
      repeat (4) @(negedge clk);
      src[b] = 1'b1;
      n = 0;
      while (go_r !== 1'b1 && n < 8)
      begin
         @(negedge clk);
         n++;
      end
   endtask
   task automatic set_mode(input adc_ctrl_pkg::mode_t m, input logic [2:0] sh, input logic [7:0] r,
                           input logic d);
      cfg.mode = m;
      cfg.shift_amount = sh;
      cfg.rpt = r;
      cfg.double_sample_enable = d;
   endtask
   initial
   begin
      {adc_on, sleep_mode, rc, go_set, clr_set, done_clr, thr_clr, pump_en, thr_in} = 9'h101;
      last_raw = 12'h000;
      prev_raw = 12'h000;
      cfg = '0;
      sel = 5'h00;
      src = 32'h0000_0000;
      acq = 8'h03;
      mask = 12'hFFF;
      seed = 32'h0000_0053;
      repeat (2) @(posedge clk);
      @(negedge clk);
      sys_rst = 1'b0;
      check({acc_v, cnt_v, go_r, done_f}, 32'h0000_0000, "reset");
      pump_en = 1'b1;
      repeat (int'(adc_ctrl_pkg::PUMP_CYC)) @(negedge clk);
      check({31'h0, rdy}, 0, "pump early");
      repeat (2) @(negedge clk);
      check({31'h0, rdy}, 1, "pump ready");
      pump_en = 1'b0;
      @(negedge clk);
      check({31'h0, rdy}, 0, "pump off");
      @(negedge clk);
      go_set = 1'b1;
      n = 0;
      do
      begin
         @(negedge clk);
         go_set = 1'b0;
         n++;
      end while (conv_start !== 1'b1 && n < 50);
      check(n, acq + 2, "acquisition wait");
      wait_idle();
      set_mode(adc_ctrl_pkg::MD_BASIC, 3'h0, 8'h01, 1'b1);
      @(negedge clk);
      go_set = 1'b1;
      @(negedge clk);
      go_set = 1'b0;
      while (conv_done !== 1'b1)
         @(negedge clk);
      repeat (3) @(negedge clk);
      check({31'h0, done_f}, 0, "done after one of two");
      wait_idle();
      set_mode(adc_ctrl_pkg::MD_ACCUM, 3'h2, 8'h01, 1'b1);
      repeat (3) run_go();
      set_mode(adc_ctrl_pkg::MD_ACCUM, 3'h3, 8'h01, 1'b0);
      mask = 12'h01F;
      acq = 8'h00;
      repeat (258)
      begin
         repeat (4) @(negedge clk); // software waits acquisition itself
         run_go();
      end
      acq = 8'h02;
      mask = 12'hFFF;
      clr_set = 1'b1;
      @(negedge clk);
      clr_set = 1'b0;
      check({31'h0, clr_cmd}, 1, "clear command");
      repeat (3) @(negedge clk);
      check({clr_cmd, ovf_f, acc_v, cnt_v}, 32'h0000_0000, "cleared");
      acc = 0;
      cnt = 0;
      set_mode(adc_ctrl_pkg::MD_AVG, 3'h1, 8'h02, 1'b0);
      thr_clr = 1'b1;
      @(negedge clk);
      thr_clr = 1'b0;
      run_go();
      check({31'h0, thr_f}, 0, "no test below target");
      run_go();
      check({31'h0, thr_f}, 1, "test at target");
      run_go();
      set_mode(adc_ctrl_pkg::MD_BURST, 3'h2, 8'h04, 1'b0);
      run_go();
      set_mode(adc_ctrl_pkg::MD_LPF, 3'h1, 8'h02, 1'b0);
      repeat (3) run_go();
      set_mode(adc_ctrl_pkg::MD_BASIC, 3'h1, 8'h01, 1'b0); // filter output keeps the last shift
      sel = seed[4:0];
      edge_on((int'(sel) + 1) % 32);
      check({31'h0, go_r}, 0, "other source ignored");
      edge_on(int'(sel)); // triggers spaced past completion
      check({31'h0, go_r}, 1, "hardware start");
      wait_idle();
      sleep_mode = 1'b1;
      edge_on(int'(sel));
      repeat (10) @(negedge clk);
      check({31'h0, go_r}, 0, "held in sleep");
      sleep_mode = 1'b0;
      n = 0;
      while (go_r !== 1'b1 && n < 8)
      begin
         @(negedge clk);
         n++;
      end
      check({31'h0, go_r}, 1, "start after sleep");
      wait_idle();
      sleep_mode = 1'b1;
      rc = 1'b1;
      edge_on(int'(sel));
      check({31'h0, go_r}, 1, "sleep start on rc clock");
      wait_idle();
      finish_test();
   end
endmodule
`default_nettype wire
